//--- design/asram_regs.svh
`ifndef ASRAM_REGS_SVH
`define ASRAM_REGS_SVH

`define ASRAM_ADDR_W 14
`define ASRAM_DATA_W 4
`define ASRAM_CLK_PERIOD_NS 25
// Read cycle and access times, 15 ns grade
`define ASRAM_T_RC_NS 15
`define ASRAM_T_AA_NS 15
`define ASRAM_T_ACE_NS 15
`define ASRAM_T_DOE_NS 10
`define ASRAM_T_HZ_NS 8
// Write cycle, 15 ns grade
`define ASRAM_T_SD_NS 10
`define ASRAM_T_AW_NS 12
`define ASRAM_T_PWE_NS 12
`define ASRAM_T_SCE_NS 12
// Least times round up to whole cycles, never below one
`define ASRAM_CYC_UP(ns) (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_RD_CYC `ASRAM_CYC_UP(`ASRAM_T_AA_NS)
`define ASRAM_WR_CYC `ASRAM_CYC_UP(`ASRAM_T_AW_NS)
`define ASRAM_TURN_CYC `ASRAM_CYC_UP(`ASRAM_T_HZ_NS)
`define ASRAM_CNT_W 4

`endif

//--- design/asram_pkg.sv
package asram_pkg;

`include "asram_regs.svh"

  typedef enum logic [5:0] {
    ASRAM_IDLE = 6'h01,
    ASRAM_RD_WAIT = 6'h02,
    ASRAM_RD_DONE = 6'h04,
    ASRAM_WR_PULSE = 6'h08,
    ASRAM_WR_END = 6'h10,
    ASRAM_TURN = 6'h20
  } asram_state_t;

  typedef logic [`ASRAM_ADDR_W-1:0] asram_addr_t;
  typedef logic [`ASRAM_DATA_W-1:0] asram_data_t;

endpackage : asram_pkg

//--- design/asram_delay_cnt.sv
`timescale 1ns/1ps
`include "asram_regs.svh"

module asram_delay_cnt (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [`ASRAM_CNT_W-1:0] count,
  output logic done
);

  logic [`ASRAM_CNT_W-1:0] remain;
  logic [`ASRAM_CNT_W-1:0] next_remain;

  always_comb begin
    next_remain = remain;
    if (load) begin
      next_remain = count;
    end else if (remain != '0) begin
      next_remain = remain - `ASRAM_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  // Reaches one on the last cycle of the wait
  assign done = (remain == `ASRAM_CNT_W'(1));

endmodule : asram_delay_cnt

//--- design/asram_ctrl.sv
`timescale 1ns/1ps
`include "asram_regs.svh"

module asram_ctrl
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`ASRAM_ADDR_W-1:0] req_addr,
  input wire logic [`ASRAM_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`ASRAM_DATA_W-1:0] rsp_rdata,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic [`ASRAM_ADDR_W-1:0] address_line,
  output logic [`ASRAM_DATA_W-1:0] data_pin_out,
  output logic data_pin_oe,
  input wire logic [`ASRAM_DATA_W-1:0] data_pin_in
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  asram_state_t state;
  asram_state_t next_state;
  logic next_chip_select_n;
  logic next_write_strobe_n;
  logic next_output_gate_n;
  logic next_data_pin_oe;
  logic next_rsp_valid;
  asram_addr_t next_address_line;
  asram_data_t next_data_pin_out;
  asram_data_t next_rsp_rdata;
  asram_data_t pin_meta;
  asram_data_t pin_sync;
  asram_data_t next_pin_meta;
  asram_data_t next_pin_sync;
  logic cnt_load;
  logic [`ASRAM_CNT_W-1:0] cnt_value;
  logic cnt_done;

  // ----------------------------------------
  // Wait counter
  // ----------------------------------------
  asram_delay_cnt u_wait (
    .clk(clk),
    .nrst(nrst),
    .load(cnt_load),
    .count(cnt_value),
    .done(cnt_done)
  );

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Pins come from outside the clock domain; two stages, and the read
  // wait adds one cycle per stage so the second stage holds settled data
  always_comb begin
    next_pin_meta = data_pin_in;
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // Only idle takes a request, so the pins never see two owners at once
  assign req_ready = (state == ASRAM_IDLE);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_chip_select_n = chip_select_n;
    next_write_strobe_n = write_strobe_n;
    next_output_gate_n = output_gate_n;
    next_data_pin_oe = data_pin_oe;
    next_address_line = address_line;
    next_data_pin_out = data_pin_out;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    cnt_load = 1'b0;
    cnt_value = '0;
    case (state)
      ASRAM_IDLE: begin
        if (req_valid) begin
          // Address, select, and gate (strobe on a write) move together; access counted from here
          next_address_line = req_addr;
          next_chip_select_n = 1'b0;
          cnt_load = 1'b1;
          if (req_write) begin
            next_output_gate_n = 1'b1;
            next_write_strobe_n = 1'b0;
            next_data_pin_out = req_wdata;
            next_data_pin_oe = 1'b1;
            cnt_value = `ASRAM_CNT_W'(`ASRAM_WR_CYC + 1);
            next_state = ASRAM_WR_PULSE;
          end else begin
            next_output_gate_n = 1'b0;
            // Extra two for the synchroniser depth
            cnt_value = `ASRAM_CNT_W'(`ASRAM_RD_CYC + 2);
            next_state = ASRAM_RD_WAIT;
          end
        end
      end
      ASRAM_RD_WAIT: begin
        if (cnt_done) begin
          next_rsp_rdata = pin_sync;
          next_rsp_valid = 1'b1;
          next_chip_select_n = 1'b1;
          next_output_gate_n = 1'b1;
          next_state = ASRAM_RD_DONE;
        end
      end
      ASRAM_RD_DONE: begin
        // Memory may still drive for its float delay; keep our driver off
        cnt_load = 1'b1;
        cnt_value = `ASRAM_CNT_W'(`ASRAM_TURN_CYC + 1);
        next_state = ASRAM_TURN;
      end
      ASRAM_WR_PULSE: begin
        if (cnt_done) begin
          // Strobe and select rise together; strobe is the ending edge
          next_write_strobe_n = 1'b1;
          next_chip_select_n = 1'b1;
          next_state = ASRAM_WR_END;
        end
      end
      ASRAM_WR_END: begin
        // Data and address held through the ending edge; data driver released after
        next_data_pin_oe = 1'b0;
        next_state = ASRAM_IDLE;
      end
      ASRAM_TURN: begin
        if (cnt_done) begin
          next_state = ASRAM_IDLE;
        end
      end
      default: begin
        next_state = ASRAM_IDLE;
        next_chip_select_n = 1'b1;
        next_write_strobe_n = 1'b1;
        next_output_gate_n = 1'b1;
        next_data_pin_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ASRAM_IDLE;
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_gate_n <= 1'b1;
      data_pin_oe <= 1'b0;
      address_line <= '0;
      data_pin_out <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      state <= next_state;
      chip_select_n <= next_chip_select_n;
      write_strobe_n <= next_write_strobe_n;
      output_gate_n <= next_output_gate_n;
      data_pin_oe <= next_data_pin_oe;
      address_line <= next_address_line;
      data_pin_out <= next_data_pin_out;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

endmodule : asram_ctrl

//--- tb/asram_mem_model.sv
`timescale 1ns/1ps
// ----
// Memory at the pins
// ----
module asram_mem_model
  import asram_pkg::*;
#(parameter int T_ACC = 15)
(
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic gate_n,
  input wire asram_addr_t addr,
  input wire asram_data_t din,
  output asram_data_t dout,
  output logic drive
);
  asram_data_t mem [0:16383];
  logic wr;
  assign wr = !cs_n && !we_n;
  assign drive = !cs_n && we_n && !gate_n;
  initial dout = 4'hA;
  // First rising edge of strobe or select ends the write
  always @(negedge wr) mem[addr] = din;
  // Old data lingers, then garbage until access time, so early sampling shows
  always @(drive or addr) begin
    #3 dout = ~dout;
    #(T_ACC - 3) if (drive) dout = mem[addr];
  end
endmodule : asram_mem_model

//--- tb/asram_ctrl_checker.sv
`timescale 1ns/1ps
// ----
// Pin protocol checks
// ----
module asram_ctrl_checker
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire asram_addr_t address_line,
  input wire asram_data_t data_pin_out,
  input wire logic data_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_go;
    $fell(chip_select_n) && write_strobe_n;
  endsequence
  sequence rd_hold;
    (!chip_select_n && !output_gate_n && $stable(address_line))[*2];
  endsequence
  a_wr_pulse_len: assert property ($fell(write_strobe_n) |->
    !chip_select_n ##1 !write_strobe_n ##1 write_strobe_n) else $error("wr pulse");
  a_wr_end_edge: assert property ($rose(write_strobe_n) |-> $rose(chip_select_n))
    else $error("wr end");
  a_wr_hold: assert property (!$past(write_strobe_n) |-> data_pin_oe &&
    $stable(address_line) && $stable(data_pin_out)) else $error("wr hold");
  a_wr_data_early: assert property ($fell(write_strobe_n) |-> data_pin_oe)
    else $error("wr data");
  a_rd_window: assert property (rd_go |=> rd_hold ##1 chip_select_n && rsp_valid)
    else $error("rd window");
  a_take_read: assert property (req_valid && req_ready && !req_write |=>
    $fell(chip_select_n) ##3 rsp_valid) else $error("rd take");
  a_float_gap: assert property ($rose(chip_select_n) && rsp_valid |->
    chip_select_n[*3]) else $error("float gap");
  a_busy_ready: assert property (!chip_select_n |-> !req_ready)
    else $error("busy ready");
  a_gate_no_drive: assert property (!output_gate_n |-> !data_pin_oe)
    else $error("gate clash");
endmodule : asram_ctrl_checker

bind asram_ctrl asram_ctrl_checker i_chk (.clk, .nrst, .req_valid, .req_write,
  .req_ready, .rsp_valid, .chip_select_n, .write_strobe_n, .output_gate_n,
  .address_line, .data_pin_out, .data_pin_oe);

//--- tb/asram_ctrl_bench.sv
`timescale 1ns/1ps
module asram_ctrl_bench
  import asram_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  asram_addr_t req_addr = 14'h0000, address_line;
  asram_data_t req_wdata = 4'h0, rsp_rdata, data_pin_out, mem_q, data_pin_in;
  logic req_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n;
  logic data_pin_oe, mem_drive;
  int bad_count = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  // Undriven pins read as the inverse of the last value, so a stray sample shows
  assign data_pin_in = data_pin_oe ? data_pin_out : (mem_drive ? mem_q : ~mem_q);
  asram_ctrl i_dut (.clk, .nrst, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .chip_select_n, .write_strobe_n, .output_gate_n,
    .address_line, .data_pin_out, .data_pin_oe, .data_pin_in);
  asram_mem_model i_mem (.cs_n(chip_select_n), .we_n(write_strobe_n),
    .gate_n(output_gate_n), .addr(address_line), .din(data_pin_in), .dout(mem_q),
    .drive(mem_drive));
  // ----
  // Tasks
  // ----
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic req(input logic w, input asram_addr_t a, input asram_data_t d);
    while (req_ready !== 1'b1) @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
  endtask : req
  task automatic wr(input asram_addr_t a, input asram_data_t d);
    req(1'b1, a, d);
    chk("oe", 14'h0001, {13'h0000, data_pin_oe});
    chk("waddr", a, address_line);
  endtask : wr
  task automatic rd(input asram_addr_t a, input asram_data_t e);
    int i;
    req(1'b0, a, 4'h0);
    chk("addr", a, address_line);
    for (i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(negedge clk);
    chk("rsp", 14'h0001, {13'h0000, rsp_valid});
    chk("rdata", {10'h000, e}, {10'h000, rsp_rdata});
  endtask : rd
  // ----
  // Scenarios
  // ----
  task automatic t_wr_rd;
    wr(14'h0000, 4'h5);
    wr(14'h3FFF, 4'hA);
    wr(14'h1555, 4'hF);
    rd(14'h3FFF, 4'hA);
    rd(14'h0000, 4'h5);
    wr(14'h1555, 4'h0);
    rd(14'h1555, 4'h0);
    $display("done wr_rd");
  endtask : t_wr_rd
  task automatic t_mid_reset;
    req(1'b1, 14'h2AAA, 4'hC);
    nrst = 1'b0;
    #1 chk("cs_n", 14'h0001, {13'h0000, chip_select_n});
    chk("we_n", 14'h0001, {13'h0000, write_strobe_n});
    @(negedge clk);
    nrst = 1'b1;
    rd(14'h3FFF, 4'hA);
    $display("done mid_reset");
  endtask : t_mid_reset
  initial begin
    repeat (10) @(negedge clk);
    chk("rst_oe", 14'h0000, {13'h0000, data_pin_oe});
    chk("rst_cs", 14'h0001, {13'h0000, chip_select_n});
    chk("rst_ready", 14'h0001, {13'h0000, req_ready});
    nrst = 1'b1;
    t_wr_rd();
    t_mid_reset();
    end_of_test();
  end
  // Run takes about 55 cycles; hang cut far beyond it
  initial begin
    #(25 * 3000);
    bad_count++;
    end_of_test();
  end
endmodule : asram_ctrl_bench
